// ==== logic/dio_pkg.sv ====
package dio_pkg;

  localparam int DIO_LINES = 7;

  // timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int PULSE_LOW_NS    = 30_000;
  // driven pulse is exact, received pulse is a least width: both round up
  localparam int PULSE_LOW_CYC   = (PULSE_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] DIO_CFG_BASE   = 8'h00;  // 0x00..0x18, one per line
  localparam logic [7:0] DIO_OUTV_OFS   = 8'h20;
  localparam logic [7:0] DIO_INST_OFS   = 8'h24;
  localparam logic [7:0] DIO_PWMP_BASE  = 8'h40;  // period in cycles, 0x40..0x58
  localparam logic [7:0] DIO_PWML_BASE  = 8'h60;  // low time in cycles, 0x60..0x78
  localparam logic [7:0] DIO_EVT_OFS    = 8'h80;

  // line configuration register fields
  localparam int CFG_MODE_LSB = 0;   // [1:0] mode
  localparam int CFG_INV_BIT  = 2;
  localparam int CFG_PWM_BIT  = 3;   // output mode: 1 selects pwm
  localparam logic [3:0] CFG_RST = 4'h0;

  // 100 Hz, 10 % low at 20 MHz
  localparam logic [23:0] PWM_PER_RST = 24'd200000;
  localparam logic [23:0] PWM_LOW_RST = 24'd20000;

  // event register bits
  localparam int EVT_CLEAR_BIT = 0;
  localparam int EVT_TRIG_BIT  = 1;
  localparam int EVT_SON_BIT   = 2;
  localparam int EVT_SOFF_BIT  = 3;

  typedef enum logic [1:0] {
    DIO_MODE_DEFAULT = 2'h0,
    DIO_MODE_INPUT   = 2'h1,
    DIO_MODE_OUTPUT  = 2'h2
  } dio_mode_t;

  typedef struct packed {
    logic      pwm;
    logic      inv;
    dio_mode_t mode;
  } dio_cfg_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } dio_wb_req_t;

endpackage

// ==== logic/dio_sync_qual.sv ====
`timescale 1ns/1ps
module dio_sync_qual
  import dio_pkg::*;
#(
  parameter int MIN_LOW = PULSE_LOW_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin side
  input  wire logic pin_i,
  // clean level and qualified falling pulse
  output logic      level_o,
  output logic      pulse_o
);
  logic       s1_q, s2_q, s3_q;
  logic       lvl_q;
  logic [15:0] cnt_q;
  logic       done_q;
  wire        agree = (s2_q == s3_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_i;   // synchroniser ahead of any edge logic
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= 1'b1;
    end else if (agree) begin
      lvl_q <= s3_q;
    end
  end

  // low must hold MIN_LOW cycles; pulse fires once at that moment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= 16'h0000;
      done_q  <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (lvl_q) begin
        cnt_q  <= 16'h0000;
        done_q <= 1'b0;
      end else if (!done_q) begin
        if (cnt_q == 16'(MIN_LOW - 1)) begin
          done_q  <= 1'b1;
          pulse_o <= 1'b1;   // [R11] [R5]
        end
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign level_o = lvl_q;
endmodule

// ==== logic/dio_pwm.sv ====
`timescale 1ns/1ps
module dio_pwm
  import dio_pkg::*;
#(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // settings
  input  wire logic [W-1:0] period_i,
  input  wire logic [W-1:0] low_i,
  input  wire logic         run_i,
  // waveform, high during the high part
  output logic              wave_o
);
  logic [W-1:0] cnt_q, per_q, low_q;
  // an idle line sits at a period end, so new settings load at once on entry
  wire          last = !run_i || (cnt_q >= per_q - W'(1)) || (per_q == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      per_q  <= W'(PWM_PER_RST);
      low_q  <= W'(PWM_LOW_RST);
      wave_o <= 1'b1;
    end else begin
      if (last) begin
        cnt_q <= '0;
        per_q <= period_i;   // [R20]
        low_q <= low_i;      // [R20]
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
      // low fraction comes first in each period
      wave_o <= !((last ? W'(0) : cnt_q + W'(1)) < (last ? low_i : low_q));  // [R8]
    end
  end
endmodule

// ==== logic/dio_port.sv ====
`timescale 1ns/1ps
// Function
// [R1] seven lines: default, input or output
// [R2] line1 clear pulse, 2 protect, 3 output
// [R3] line4 trigger in, line5 emergency inhibit
// [R4] line6 sync on, line7 sync off
// [R5] pulses are high to low transitions
// [R6] static output: true drives low
// [R7] input lines sampled, state readable
// [R8] pwm from period and low time
// [R9] per-line polarity inverts in and out
// [R10] inhibit active high, low when inverted
// [R11] received clear pulse low at least 30us; with inverted polarity the rising edge counts, unchecked for width
// [R12] line one bidirectional in default role
// [R13] valid clear pulse clears protection
// [R14] off-to-on without protection emits pulse
// [R15] driven pulse low for 30us
// [R16] protect indicator low while protected
// [R17] output indicator low while output on
// [R18] external trigger starts list or logging
// [R19] two-stage synchronise all external inputs
// [R20] pwm settings change at period end
module dio_port
  import dio_pkg::*;
#(
  parameter int N   = DIO_LINES,
  parameter int PW  = 24,
  parameter int PLC = PULSE_LOW_CYC
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // wishbone slave
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic         wb_we_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // instrument state
  input  wire logic         protection_flag_i,
  input  wire logic         output_on_i,
  input  wire logic         ext_trig_sel_i,
  // instrument controls
  output logic              fault_reset_pulse_o,
  output logic              trig_start_o,
  output logic              emergency_inhibit_o,
  output logic              sync_on_o,
  output logic              sync_off_o,
  // port pins
  input  wire logic [N-1:0] pin_i,
  output logic [N-1:0]      pin_o,
  output logic [N-1:0]      pin_oe_o
);
  dio_cfg_t     cfg_q    [N];
  logic [PW-1:0] per_q   [N];
  logic [PW-1:0] low_q   [N];
  logic [N-1:0] outv_q;
  logic [3:0]   evt_q;
  logic [N-1:0] lvl, pul, pwm_w;
  logic [N-1:0] pin_d;
  logic [N-1:0] oe_d;
  logic         on_q;
  logic [15:0]  tx_cnt_q;
  logic         tx_act_q;
  logic [7:0]   rx_blank_q;
  logic [N-1:0] pwm_run;


  // register access
  // map: cfg 0x00+4i, static values 0x20, input state 0x24,
  // pwm period 0x40+4i, pwm low 0x60+4i, events 0x80; byte lanes other
  // than sel[0] are not decoded
  wire        req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr     = req && wb_we_i && wb_sel_i[0];
  wire [7:0]  ofs    = wb_adr_i & 8'hfc;
  wire [2:0]  idx    = ofs[4:2];
  wire        in_rng = (idx < 3'(N));
  wire        hit_cfg  = (ofs[7:5] == 3'h0) && in_rng;
  wire        hit_per  = (ofs[7:5] == 3'h2) && in_rng;
  wire        hit_low  = (ofs[7:5] == 3'h3) && in_rng;
  wire        hit_outv = (ofs == DIO_OUTV_OFS);
  wire        hit_inst = (ofs == DIO_INST_OFS);
  wire        hit_evt  = (ofs == DIO_EVT_OFS);
  // write strobes; pwm fields are whole words and ignore sel
  wire        wr_cfg   = wr && hit_cfg;
  wire        wr_outv  = wr && hit_outv;
  wire        wr_evt   = wr && hit_evt;
  wire        wr_per   = req && wb_we_i && hit_per;
  wire        wr_low   = req && wb_we_i && hit_low;

  function automatic logic is_mode(dio_cfg_t c, dio_mode_t m);
    return c.mode == m;
  endfunction

  // polarity applied to received levels, giving logical value (1 = active)
  logic [N-1:0] act;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      act[i] = lvl[i] ^ cfg_q[i].inv;   // [R9]
    end
  end

  // unmapped offsets read zero and drop writes
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    if (hit_cfg) rd = {28'h0, cfg_q[idx]};
    else if (hit_per) rd = 32'(per_q[idx]);
    else if (hit_low) rd = 32'(low_q[idx]);
    else if (hit_outv) rd = 32'(outv_q);
    else if (hit_inst) rd = 32'(act);   // [R7]
    else if (hit_evt) rd = {28'h0, evt_q};
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      dio_sync_qual #(.MIN_LOW(PLC)) u_sq (   // [R19]
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_i[g]),
        .level_o (lvl[g]),
        .pulse_o (pul[g])
      );
      // generator only runs while its line actually shows the waveform
      assign pwm_run[g] = is_mode(cfg_q[g], DIO_MODE_OUTPUT) && cfg_q[g].pwm;
      dio_pwm #(.W(PW)) u_pwm (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .period_i (per_q[g]),
        .low_i    (low_q[g]),
        .run_i    (pwm_run[g]),
        .wave_o   (pwm_w[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        cfg_q[i] <= dio_cfg_t'(CFG_RST);   // [R1]
        per_q[i] <= PW'(PWM_PER_RST);
        low_q[i] <= PW'(PWM_LOW_RST);
      end
      outv_q <= '0;
    end else begin
      if (wr_cfg) cfg_q[idx] <= dio_cfg_t'(wb_dat_i[3:0]);
      if (wr_outv) outv_q <= wb_dat_i[N-1:0];
      if (wr_per) per_q[idx] <= PW'(wb_dat_i);
      if (wr_low) low_q[idx] <= PW'(wb_dat_i);
    end
  end

  // bus answer: one wait state, ack and data stand for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd : 32'h0000_0000;
    end
  end

  // qualified falling pulses on default-role lines; inverted polarity
  // makes the rising edge the event, taken here from the clean level
  logic [N-1:0] lvl_q;
  logic [N-1:0] ev;
  // reset high matches the idle pull-up, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) lvl_q <= '1;
    else lvl_q <= lvl;
  end
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ev[i] = is_mode(cfg_q[i], DIO_MODE_DEFAULT) &&
              (cfg_q[i].inv ? (lvl[i] && !lvl_q[i]) : pul[i]);   // [R5] [R9]
    end
  end

  // our own pulse comes back through the synchroniser and the width check
  // after the drive is released, so line one stays deaf for a short tail
  always_ff @(posedge clk_i) begin
    if (rst_i) rx_blank_q <= 8'h00;
    else rx_blank_q <= {rx_blank_q[6:0], tx_act_q};
  end
  wire       line1_rx = ev[0] && !tx_act_q && !(|rx_blank_q);   // [R12]
  wire [3:0] evt_set  = {ev[6], ev[5], ev[3], line1_rx};
  wire [3:0] evt_clr  = wr_evt ? wb_dat_i[3:0] : 4'h0;

  // set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= 4'h0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // line one transmit pulse on output switch off-to-on
  wire on_rise = output_on_i && !on_q;
  // a second rise inside a running pulse is dropped, not queued
  wire tx_go   = !tx_act_q && on_rise && !protection_flag_i &&
                 is_mode(cfg_q[0], DIO_MODE_DEFAULT);   // [R14]

  always_ff @(posedge clk_i) begin
    if (rst_i) on_q <= 1'b0;
    else on_q <= output_on_i;
  end

  // counter runs while the pulse stands; low width is PLC cycles exactly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_act_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
    end else begin
      if (tx_go) begin
        tx_act_q <= 1'b1;
        tx_cnt_q <= 16'(PLC - 1);
      end else if (tx_act_q) begin
        if (tx_cnt_q == 16'h0000) tx_act_q <= 1'b0;   // [R15]
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end
    end
  end

  wire clr_d  = line1_rx && protection_flag_i;                  // [R13] [R11]
  wire trig_d = ev[3] && ext_trig_sel_i;                        // [R3] [R18]
  wire inh_d  = is_mode(cfg_q[4], DIO_MODE_DEFAULT) && act[4];  // [R3] [R10]

  // instrument-side controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reset_pulse_o <= 1'b0;
      trig_start_o        <= 1'b0;
      sync_on_o           <= 1'b0;
      sync_off_o          <= 1'b0;
    end else begin
      fault_reset_pulse_o <= clr_d;
      trig_start_o        <= trig_d;
      sync_on_o           <= ev[5];                             // [R4]
      sync_off_o          <= ev[6];                             // [R4]
    end
  end

  // inhibit is a level and follows line five for as long as it stands
  always_ff @(posedge clk_i) begin
    if (rst_i) emergency_inhibit_o <= 1'b0;
    else emergency_inhibit_o <= inh_d;
  end

  // pin drive: compute active-low logical level, then polarity
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_d[i] = 1'b1;
      oe_d[i]  = 1'b0;
      unique case (cfg_q[i].mode)
        DIO_MODE_OUTPUT: begin
          oe_d[i]  = 1'b1;
          pin_d[i] = cfg_q[i].pwm ? pwm_w[i] : !outv_q[i];   // [R6] [R8]
        end
        DIO_MODE_DEFAULT: begin
          if (i == 0) begin
            oe_d[i]  = tx_act_q;   // [R12]
            pin_d[i] = 1'b0;       // [R5] [R15]
          end else if (i == 1) begin
            oe_d[i]  = 1'b1;
            pin_d[i] = !protection_flag_i;   // [R2] [R16]
          end else if (i == 2) begin
            oe_d[i]  = 1'b1;
            pin_d[i] = !output_on_i;         // [R2] [R17]
          end
        end
        default: begin
          oe_d[i]  = 1'b0;   // input mode and the unused code listen only
          pin_d[i] = 1'b1;
        end
      endcase
      if (cfg_q[i].inv) pin_d[i] = !pin_d[i];   // [R9]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= '1;
      pin_oe_o <= '0;
    end else begin
      pin_o    <= pin_d;
      pin_oe_o <= oe_d;
    end
  end

endmodule

// ==== tb/dio_port_props.sv ====
`timescale 1ns/1ps
module dio_port_chk
  import dio_pkg::*;
#(
  parameter int N   = DIO_LINES,
  parameter int PLC = PULSE_LOW_CYC
) (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic [7:0]   wb_adr_i,
  input wire logic [31:0]  wb_dat_i,
  input wire logic [3:0]   wb_sel_i,
  input wire logic         wb_we_i,
  input wire logic         wb_ack_o,
  input wire logic         protection_flag_i,
  input wire logic         output_on_i,
  input wire logic         ext_trig_sel_i,
  input wire logic         fault_reset_pulse_o,
  input wire logic         trig_start_o,
  input wire logic         emergency_inhibit_o,
  input wire logic [N-1:0] pin_i,
  input wire logic [N-1:0] pin_o,
  input wire logic [N-1:0] pin_oe_o
);
  logic [3:0]   cfg_q [N];
  logic [N-1:0] outv_q;
  int           tx_q, low_q, run_q;
  // mirror of writes, taken at the ack edge so it lags the design by at most one cycle
  wire          wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q  <= '{default: 4'h0};
      outv_q <= '0;
      tx_q   <= 0;
      low_q  <= 0;
      run_q  <= 0;
    end else begin
      if (wr && wb_adr_i < 8'h1c) cfg_q[wb_adr_i[4:2]] <= wb_dat_i[3:0];
      if (wr && wb_adr_i[7:2] == DIO_OUTV_OFS[7:2]) outv_q <= wb_dat_i[N-1:0];
      tx_q  <= !pin_oe_o[0] ? 0 : tx_q + int'(!pin_o[0]);
      low_q <= pin_i[0] ? 0 : low_q + 1;
      if (pin_i[0] && low_q > 0) run_q <= low_q;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_prot_level: assert property (!$past(rst_i) && cfg_q[1] == 4'h0
    |-> pin_oe_o[1] && pin_o[1] == !$past(protection_flag_i)) else $error("protect level");
  a_out_level: assert property (!$past(rst_i) && cfg_q[2] == 4'h0
    |-> pin_oe_o[2] && pin_o[2] == !$past(output_on_i)) else $error("output level");
  for (genvar i = 0; i < N; i++) begin : g_out
    a_static_out: assert property (cfg_q[i][1:0] == 2'h2 && !cfg_q[i][3]
      && $stable(cfg_q[i]) && $stable(outv_q) && !$past(rst_i)
      |-> pin_oe_o[i] && pin_o[i] == (outv_q[i] ~^ cfg_q[i][2])) else $error("static out");
  end
  a_inhibit_level: assert property ((cfg_q[4][1:0] == 2'h0 && $stable(pin_i[4])
    && $stable(cfg_q[4]))[*8] |-> emergency_inhibit_o == (pin_i[4] ^ cfg_q[4][2]))
    else $error("inhibit level");
  a_tx_start: assert property ($rose(output_on_i) && !protection_flag_i && cfg_q[0] == 4'h0
    && !pin_oe_o[0] |-> ##[1:4] $rose(pin_oe_o[0])) else $error("no pulse out");
  a_tx_low: assert property ($rose(pin_oe_o[0]) && cfg_q[0] == 4'h0 |-> !pin_o[0])
    else $error("pulse not low");
  a_tx_width: assert property ($fell(pin_oe_o[0]) && cfg_q[0] == 4'h0 |-> tx_q == PLC)
    else $error("pulse width");
  a_clear_width: assert property (fault_reset_pulse_o && cfg_q[0] == 4'h0
    |-> low_q >= PLC || run_q >= PLC) else $error("short clear");
  a_trig_gate: assert property (trig_start_o |-> $past(ext_trig_sel_i))
    else $error("trigger ungated");
  sequence s_on_edge;
    $rose(output_on_i) && !protection_flag_i && cfg_q[0] == 4'h0 && !pin_oe_o[0];
  endsequence
  sequence s_tx_body;
    (pin_oe_o[0] && !pin_o[0])[*4];
  endsequence
  a_tx_shape: assert property (s_on_edge |-> ##2 s_tx_body)
    else $error("pulse shape");
endmodule
bind dio_port dio_port_chk #(.N(N), .PLC(PLC)) dio_port_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .protection_flag_i(protection_flag_i), .output_on_i(output_on_i),
  .ext_trig_sel_i(ext_trig_sel_i), .fault_reset_pulse_o(fault_reset_pulse_o),
  .trig_start_o(trig_start_o), .emergency_inhibit_o(emergency_inhibit_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o));

// ==== tb/dio_ext_inst.sv ====
`timescale 1ns/1ps
module dio_ext_inst
  import dio_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic [DIO_LINES-1:0] drv_low_i,
  input  wire logic [DIO_LINES-1:0] dev_pin_i,
  input  wire logic [DIO_LINES-1:0] dev_oe_i,
  output logic      [DIO_LINES-1:0] pin_lvl_o,
  output int                        rx_cnt_o,
  output int                        rx_wid_o
);
  int run_q = 0;
  int cnt_q = 0;
  int wid_q = 0;
  // released lines sit at the pull-up, so a pulse is only ever a pull low
  assign pin_lvl_o = (dev_oe_i & dev_pin_i) | (~dev_oe_i & ~drv_low_i);
  assign rx_cnt_o  = cnt_q;
  assign rx_wid_o  = wid_q;
  always @(posedge clk_i) begin
    if (dev_oe_i[0] && !dev_pin_i[0]) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      cnt_q <= cnt_q + 1;
      wid_q <= run_q;
      run_q    <= 0;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import dio_pkg::*;
  localparam int PLC = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  dio_wb_req_t req   = '0;
  logic        prot = 1'b0, on = 1'b0, tsel = 1'b0, hit;
  logic [6:0]  drv_low = 7'h00;
  logic [31:0] r;
  wire  [31:0] rdat;
  wire  [3:0]  ctl;
  wire  [6:0]  lvl, po, poe;
  wire         ack, inh;
  int          failures = 0, total_checks = 0, rx_cnt, rx_wid, n;
  always #25 clk_i = ~clk_i;
  dio_port #(.PLC(PLC)) dio_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_sel_i(req.sel), .wb_we_i(req.we), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_dat_o(rdat), .wb_ack_o(ack), .protection_flag_i(prot),
    .output_on_i(on), .ext_trig_sel_i(tsel), .fault_reset_pulse_o(ctl[0]),
    .trig_start_o(ctl[1]), .emergency_inhibit_o(inh), .sync_on_o(ctl[2]),
    .sync_off_o(ctl[3]), .pin_i(lvl), .pin_o(po), .pin_oe_o(poe));
  dio_ext_inst dio_ext_inst_i (.clk_i(clk_i), .drv_low_i(drv_low), .dev_pin_i(po),
    .dev_oe_i(poe), .pin_lvl_o(lvl), .rx_cnt_o(rx_cnt), .rx_wid_o(rx_wid));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int ln, input int w);
    drv_low[ln] <= 1'b1;
    repeat (w) @(posedge clk_i);
    drv_low[ln] <= 1'b0;
  endtask
  task automatic wpulse(input int b, output logic h);
    h = 1'b0;
    repeat (PLC + 12) begin
      @(posedge clk_i);
      if (ctl[b] === 1'b1) h = 1'b1;
    end
  endtask
  task automatic edge_test(input int ln, input int b, input int w, input logic exp);
    fork
      pulse(ln, w);
      wpulse(b, hit);
    join
    chk("control pulse", hit, exp);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("drive enables", poe, 32'h6);
    chk("indicators idle", po[2:1], 32'h3);
    prot <= 1'b1;
    on   <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("indicators active", po[2:1], 32'h0);
    wb(1'b0, DIO_PWMP_BASE, 32'h0);
    chk("pwm period", r, PWM_PER_RST);
    wb(1'b0, DIO_PWML_BASE + 8'h18, 32'h0);
    chk("pwm low", r, PWM_LOW_RST);
    wb(1'b0, 8'h14, 32'h0);
    chk("cfg reset", r, CFG_RST);
    wb(1'b0, 8'h9c, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("test reset done");
    edge_test(0, 0, PLC + 4, 1'b1);
    tsel <= 1'b1;
    edge_test(3, 1, PLC - 3, 1'b0);
    edge_test(3, 1, PLC + 4, 1'b1);
    edge_test(5, 2, PLC + 4, 1'b1);
    edge_test(6, 3, PLC + 4, 1'b1);
    tsel <= 1'b0;
    edge_test(3, 1, PLC + 4, 1'b0);
    wb(1'b0, DIO_EVT_OFS, 32'h0);
    chk("events", r, 32'hf);
    wb(1'b1, DIO_EVT_OFS, 32'hf);
    wb(1'b0, DIO_EVT_OFS, 32'h0);
    chk("events cleared", r, 32'h0);
    $display("test pulses in done");
    chk("no pulse in protection", rx_cnt, 32'h0);
    on   <= 1'b0;
    prot <= 1'b0;
    repeat (3) @(posedge clk_i);
    on <= 1'b1;
    repeat (PLC + 10) @(posedge clk_i);
    chk("pulse count", rx_cnt, 32'h1);
    chk("pulse width", rx_wid, PLC);
    $display("test pulse out done");
    wb(1'b1, 8'h14, 32'h2);
    wb(1'b1, DIO_OUTV_OFS, 32'h20);
    repeat (3) @(posedge clk_i);
    chk("static true", {poe[5], po[5]}, 32'h2);
    wb(1'b1, 8'h14, 32'h6);
    repeat (3) @(posedge clk_i);
    chk("static inverted", po[5], 32'h1);
    wb(1'b1, 8'h18, 32'h1);
    drv_low[6] <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb(1'b0, DIO_INST_OFS, 32'h0);
    chk("input low", {poe[6], r[6]}, 32'h0);
    wb(1'b1, 8'h18, 32'h5);
    wb(1'b0, DIO_INST_OFS, 32'h0);
    chk("input inverted", r[6], 32'h1);
    wb(1'b1, DIO_PWMP_BASE + 8'h0c, 32'h0000_000a);
    wb(1'b1, DIO_PWML_BASE + 8'h0c, 32'h0000_0003);
    wb(1'b1, 8'h0c, 32'h0000_000a);
    repeat (12) @(posedge clk_i);
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      n += int'(!po[3]);
    end
    chk("pwm low cycles", n, 32'h6);
    $display("test general lines done");
    chk("inhibit idle high", inh, 32'h1);
    drv_low[4] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("inhibit low", inh, 32'h0);
    wb(1'b1, 8'h10, 32'h4);
    repeat (6) @(posedge clk_i);
    chk("inhibit inverted", inh, 32'h1);
    $display("test inhibit done");
    complete_run();
  end
endmodule
